// ===== design/bormc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BORMC_REGS_SVH
`define BORMC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define BORMC_CFG_OFFSET      12'h000
`define BORMC_CTRL_OFFSET     12'h004
`define BORMC_STATUS_OFFSET   12'h008

// ****************************************
// Field positions
// ****************************************
`define BORMC_CFG_MODE_LO     0
`define BORMC_CFG_MODE_HI     1
`define BORMC_CFG_LEVEL_BIT   2
`define BORMC_CTRL_SOFT_BIT   0
`define BORMC_ST_READY_BIT    0
`define BORMC_ST_ENABLE_BIT   1
`define BORMC_ST_RESET_BIT    2
`define BORMC_ST_TRIP_BIT     3
`define BORMC_ST_WAKE_BIT     4

// ****************************************
// Reset values
// ****************************************
`define BORMC_CFG_RESET       3'h3
`define BORMC_CTRL_RESET      1'h1

// ****************************************
// Timing
// ****************************************
`define BORMC_FILTER_NS       1000
`define BORMC_CLK_NS          25
`define BORMC_FILTER_CYC      ((`BORMC_FILTER_NS + `BORMC_CLK_NS - 1) \
                               / `BORMC_CLK_NS)
`define BORMC_PWRUP_CYC       16'd2560

`endif

// ===== design/bormc_pkg.sv
// Types shared by the brown-out reset mode control block
package bormc_pkg;

    // ****************************************
    // Mode field encodings
    // ****************************************
    typedef enum logic [1:0] {
        BORMC_OFF  = 2'h0,
        BORMC_SOFT = 2'h1,
        BORMC_NSLP = 2'h2,
        BORMC_ON   = 2'h3
    } bormc_mode_e;

    // ****************************************
    // Synchronised analog and pin inputs
    // ****************************************
    typedef struct packed {
        logic supplyOk;
        logic belowTrip;
        logic detReady;
        logic extResetN;
        logic sleepReq;
    } bormc_in_s;

    typedef logic [31:0] bormc_word_t;

endpackage : bormc_pkg

// ===== design/bormc_sync.sv
// Two flip-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
`default_nettype none
module bormc_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= async;
            stage2_r <= stage1_r;
        end
    end

    assign synced = stage2_r;
endmodule : bormc_sync
`default_nettype wire

// ===== design/bormc_filter.sv
// Glitch filter: asserts only after input holds longer than the count
`timescale 1ns/10ps
`default_nettype none
module bormc_filter #(
    parameter int CYCLES = 40
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic level,
    output logic      tripped
);
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic        trip_r;
    logic        trip_nxt;

    always_comb begin
        count_nxt = count_r;
        trip_nxt  = trip_r;
        if (!enable || !level) begin
            count_nxt = 16'h0000;
            trip_nxt  = 1'b0;
        end else if (count_r >= 16'(CYCLES)) begin
            trip_nxt = 1'b1;
        end else begin
            count_nxt = count_r + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= 16'h0000;
            trip_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            trip_r  <= trip_nxt;
        end
    end

    assign tripped = trip_r;
endmodule : bormc_filter
`default_nettype wire

// ===== design/bormc_top.sv
// Brown-out reset mode control with APB register access
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "bormc_regs.svh"
module bormc_top
    import bormc_pkg::*;
#(
    parameter int FILTER_CYCLES = `BORMC_FILTER_CYC,
    parameter int PWRUP_CYCLES  = `BORMC_PWRUP_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        supplyOk,
    input  wire logic        belowTripLow,
    input  wire logic        belowTripHigh,
    input  wire logic        detReady,
    input  wire logic        extResetN,
    input  wire logic        sleepReq,
    output logic             detEnable,
    output logic             levelSelect,
    output logic             sysResetN,
    output logic             cpuRun,
    output logic             inSleep
);

    // ****************************************
    // Input synchronisation
    // ****************************************
    bormc_in_s inRaw;
    bormc_in_s inSync;
    logic      tripLowS;
    logic      tripHighS;
    logic      belowTrip;

    assign inRaw = '{supplyOk: supplyOk, belowTrip: belowTripLow,
                     detReady: detReady, extResetN: extResetN,
                     sleepReq: sleepReq};

    bormc_sync #(.WIDTH(5)) u_syncMain (
        .clk    (clk),
        .rst    (rst),
        .async  (inRaw),
        .synced (inSync)
    );

    bormc_sync #(.WIDTH(1)) u_syncTrip (
        .clk    (clk),
        .rst    (rst),
        .async  (belowTripHigh),
        .synced (tripHighS)
    );

    assign tripLowS = inSync.belowTrip;

    // ****************************************
    // Registers
    // ****************************************
    logic [2:0]  cfg_r;
    logic [2:0]  cfg_nxt;
    logic        soft_r;
    logic        soft_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        ready_r;
    logic        ready_nxt;
    logic        err_r;
    logic        err_nxt;
    bormc_mode_e mode;
    logic        access;
    logic        wrDone;

    assign mode   = bormc_mode_e'(
        cfg_r[`BORMC_CFG_MODE_HI:`BORMC_CFG_MODE_LO]);
    assign access = psel && penable && !ready_r;
    // Writes land on the edge at which the access completes
    assign wrDone = psel && penable && pwrite && ready_r;

    function automatic logic addrHit(input logic [11:0] a,
                                     input logic [11:0] off);
        addrHit = (a == off);
    endfunction : addrHit

    // ****************************************
    // Sequencer state
    // ****************************************
    typedef enum logic [2:0] {
        ST_POR,
        ST_PWRUP,
        ST_BORWAIT,
        ST_RUN,
        ST_SLEEP,
        ST_WAKEWAIT
    } bormc_state_e;

    bormc_state_e state_r;
    bormc_state_e state_nxt;
    logic [15:0]  timer_r;
    logic [15:0]  timer_nxt;
    logic         detOn;
    logic         readyFlag;
    logic         tripped;
    logic         resetHold;
    logic         detEn_r;
    logic         detEn_nxt;
    logic         lvl_r;
    logic         lvl_nxt;
    logic         sysRstN_r;
    logic         sysRstN_nxt;
    logic         run_r;
    logic         run_nxt;
    logic         slp_r;
    logic         slp_nxt;
    logic         needWait;

    // Detector enable by mode, sleep state and soft bit
    always_comb begin
        case (mode)
            BORMC_ON:   detOn = 1'b1;
            BORMC_NSLP: detOn = (state_r != ST_SLEEP);
            BORMC_SOFT: detOn = soft_r;
            BORMC_OFF:  detOn = 1'b0;
            default:    detOn = 1'b0;
        endcase
    end

    assign readyFlag = detOn && inSync.detReady;
    assign belowTrip = cfg_r[`BORMC_CFG_LEVEL_BIT]
                       ? tripHighS : tripLowS;
    assign needWait  = detOn && !inSync.detReady;

    bormc_filter #(.CYCLES(FILTER_CYCLES)) u_filter (
        .clk     (clk),
        .rst     (rst),
        .enable  (detOn),
        .level   (belowTrip),
        .tripped (tripped)
    );

    // Any active source holds reset
    assign resetHold = !inSync.supplyOk || !inSync.extResetN
                       || tripped;

    // ****************************************
    // Sequencer next state
    // ****************************************
    always_comb begin
        state_nxt   = state_r;
        timer_nxt   = timer_r;
        if (resetHold) begin
            state_nxt = ST_POR;
            timer_nxt = 16'h0000;
        end else begin
            case (state_r)
                ST_POR: begin
                    state_nxt = ST_PWRUP;
                    timer_nxt = 16'h0000;
                end
                ST_PWRUP: begin
                    if (timer_r >= 16'(PWRUP_CYCLES)) begin
                        state_nxt = ST_BORWAIT;
                    end else begin
                        timer_nxt = timer_r + 16'h0001;
                    end
                end
                ST_BORWAIT: begin
                    if (!needWait) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (inSync.sleepReq) begin
                        state_nxt = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (!inSync.sleepReq) begin
                        if (mode == BORMC_NSLP) begin
                            state_nxt = ST_WAKEWAIT;
                        end else begin
                            state_nxt = ST_RUN;
                        end
                    end
                end
                ST_WAKEWAIT: begin
                    if (!needWait) begin
                        state_nxt = ST_RUN;
                    end
                end
                default: state_nxt = ST_POR;
            endcase
        end
        sysRstN_nxt = !resetHold && (state_nxt != ST_POR)
                      && (state_nxt != ST_PWRUP);
        run_nxt     = (state_nxt == ST_RUN);
        detEn_nxt   = detOn;
        lvl_nxt     = cfg_r[`BORMC_CFG_LEVEL_BIT];
        slp_nxt     = (state_nxt == ST_SLEEP);
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_comb begin
        cfg_nxt   = cfg_r;
        soft_nxt  = soft_r;
        rdata_nxt = 32'h00000000;
        ready_nxt = access;
        err_nxt   = 1'b0;
        if (access) begin
            if (addrHit(paddr, `BORMC_CFG_OFFSET)) begin
                rdata_nxt = {29'h0, cfg_r};
            end else if (addrHit(paddr, `BORMC_CTRL_OFFSET)) begin
                rdata_nxt = {31'h0, soft_r};
            end else if (addrHit(paddr, `BORMC_STATUS_OFFSET)) begin
                rdata_nxt = {27'h0, slp_r, tripped, !sysRstN_r,
                             detEn_r, readyFlag};
            end else begin
                err_nxt = 1'b1;
            end
        end
        if (wrDone && addrHit(paddr, `BORMC_CFG_OFFSET)) begin
            cfg_nxt = pwdata[2:0];
        end
        if (wrDone && addrHit(paddr, `BORMC_CTRL_OFFSET)) begin
            soft_nxt = pwdata[`BORMC_CTRL_SOFT_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r   <= `BORMC_CFG_RESET;
            soft_r  <= `BORMC_CTRL_RESET;
            rdata_r <= 32'h00000000;
            ready_r <= 1'b0;
            err_r   <= 1'b0;
        end else begin
            cfg_r   <= cfg_nxt;
            soft_r  <= soft_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            err_r   <= err_nxt;
        end
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_POR;
            timer_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            detEn_r   <= 1'b0;
            lvl_r     <= 1'b0;
            sysRstN_r <= 1'b0;
            run_r     <= 1'b0;
            slp_r     <= 1'b0;
        end else begin
            detEn_r   <= detEn_nxt;
            lvl_r     <= lvl_nxt;
            sysRstN_r <= sysRstN_nxt;
            run_r     <= run_nxt;
            slp_r     <= slp_nxt;
        end
    end

    // ****************************************
    // Port drivers
    // ****************************************
    assign prdata      = rdata_r;
    assign pready      = ready_r;
    assign pslverr     = err_r;
    assign detEnable   = detEn_r;
    assign levelSelect = lvl_r;
    assign sysResetN   = sysRstN_r;
    assign cpuRun      = run_r;
    assign inSleep     = slp_r;

endmodule : bormc_top
`default_nettype wire

// ===== tb/bormc_top_assertions.sv
// Assertions on the brown-out reset mode control ports
`timescale 1ns/10ps
`default_nettype none
module bormc_top_assertions
    import bormc_pkg::*;
#(
    parameter int FILTER_CYCLES = 4,
    parameter int PWRUP_CYCLES  = 8
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        supplyOk,
    input wire logic        extResetN,
    input wire logic        detEnable,
    input wire logic        levelSelect,
    input wire logic        sysResetN,
    input wire logic        cpuRun,
    input wire logic        inSleep
);
    // ****
    // Mirror of mode and level, count of cycles with good supply and reset pin high
    // ****
    logic [2:0]  cfg_r;
    logic [2:0]  cfg_nxt;
    logic [15:0] good_r;
    logic [15:0] good_nxt;
    logic        cfgWr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    assign cfgWr = psel && penable && pready && pwrite && paddr == 12'h000;
    always_comb begin
        cfg_nxt = cfgWr ? pwdata[2:0] : cfg_r;
        good_nxt = &good_r ? good_r : good_r + 16'h1;
        if (!(supplyOk && extResetN)) good_nxt = 16'h0;
    end
    always_ff @(posedge clk) begin
        cfg_r <= rst ? 3'h3 : cfg_nxt;
        good_r <= rst ? 16'h0 : good_nxt;
    end
    a_slverr_map: assert property (pready |->
        pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("pslverr does not match address map");
    a_supply_reset: assert property (!supplyOk [*4] |-> !sysResetN)
        else $error("low supply did not hold reset");
    a_pin_reset: assert property (!extResetN [*4] |-> !sysResetN)
        else $error("reset pin did not hold reset");
    a_pwrup_hold: assert property ($rose(sysResetN) |->
        good_r >= 16'(PWRUP_CYCLES)) else $error("reset released early");
    a_run_release: assert property (cpuRun |-> sysResetN)
        else $error("execution while in reset");
    a_off_disable: assert property ((cfg_r[1:0] == BORMC_OFF) [*3]
        |-> !detEnable) else $error("detector on in off mode");
    a_on_enable: assert property (
        (cfg_r[1:0] == BORMC_ON && sysResetN) [*3] |-> detEnable)
        else $error("detector off in always-on mode");
    a_sleep_disable: assert property (
        (cfg_r[1:0] == BORMC_NSLP && inSleep) [*3] |-> !detEnable)
        else $error("detector on in sleep");
    a_level_copy: assert property (
        cfgWr |-> ##2 levelSelect == cfg_r[2])
        else $error("level select not copied");
endmodule : bormc_top_assertions
bind bormc_top bormc_top_assertions #(
    .FILTER_CYCLES(FILTER_CYCLES),
    .PWRUP_CYCLES (PWRUP_CYCLES)
) u_chk (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .supplyOk, .extResetN, .detEnable, .levelSelect, .sysResetN, .cpuRun,
    .inSleep
);
`default_nettype wire

// ===== tb/bormc_top_test.sv
// Directed testbench for the brown-out reset mode control block
`timescale 1ns/10ps
`default_nettype none
module bormc_top_test;
    import bormc_pkg::*;
    // ****
    // Stimulus, design and helpers
    // ****
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic supplyOk = 1'b0, belowTripLow = 1'b0, belowTripHigh = 1'b0;
    logic detReady = 1'b0, extResetN = 1'b0, sleepReq = 1'b0;
    logic pready, pslverr, detEnable, levelSelect, sysResetN, cpuRun, inSleep;
    logic [4:0] outs;
    int miscompares = 0, checks = 0;
    assign outs = {detEnable, levelSelect, inSleep, cpuRun, sysResetN};
    bormc_top #(.FILTER_CYCLES(4), .PWRUP_CYCLES(8)) dut (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .supplyOk, .belowTripLow, .belowTripHigh,
        .detReady, .extResetN, .sleepReq, .detEnable, .levelSelect,
        .sysResetN, .cpuRun, .inSleep);
    initial forever #12.5 clk = ~clk;
    task automatic check(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check("pready", 32'(pready), 32'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] m, x,
                      input logic ee);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check("prdata", q & m, x);
        check("pslverr", 32'(e), 32'(ee));
    endtask : rd
    task automatic waitfor(input int s, input logic v);
        int n;
        n = 0;
        while (outs[s] !== v && n < 300) begin
            @(posedge clk);
            n++;
        end
        check($sformatf("output %0d", s), 32'(outs[s]), 32'(v));
    endtask : waitfor
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    initial begin
        #(25 * 5000);
        miscompares++;
        close_out();
    end
    // ****
    // Sequence
    // ****
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("reset outs", 32'({pready, pslverr, outs}), 32'h0);
        rd(12'h000, 32'hffffffff, 32'h3, 1'b0);
        rd(12'h004, 32'hffffffff, 32'h1, 1'b0);
        rd(12'h00c, 32'hffffffff, 32'h0, 1'b1);
        supplyOk <= 1'b1;
        extResetN <= 1'b1;
        detReady <= 1'b1;
        waitfor(0, 1'b1);
        waitfor(1, 1'b1);
        rd(12'h008, 32'h1f, 32'h3, 1'b0);
        wr(12'h000, 32'h7);
        waitfor(3, 1'b1);
        {belowTripLow, belowTripHigh} <= 2'h2;
        repeat (20) @(posedge clk);
        check("sysResetN", 32'(sysResetN), 32'h1);
        {belowTripLow, belowTripHigh} <= 2'h3;
        repeat (3) @(posedge clk);
        {belowTripLow, belowTripHigh} <= 2'h0;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            check("sysResetN", 32'(sysResetN), 32'h1);
        end
        {belowTripLow, belowTripHigh} <= 2'h3;
        waitfor(0, 1'b0);
        {belowTripLow, belowTripHigh} <= 2'h0;
        waitfor(1, 1'b1);
        extResetN <= 1'b0;
        waitfor(0, 1'b0);
        extResetN <= 1'b1;
        waitfor(1, 1'b1);
        supplyOk <= 1'b0;
        waitfor(0, 1'b0);
        supplyOk <= 1'b1;
        waitfor(1, 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(12'h000, 32'(m));
            waitfor(4, m != 0);
            rd(12'h008, 32'h3, m != 0 ? 32'h3 : 32'h0, 1'b0);
        end
        wr(12'h000, 32'h1);
        wr(12'h004, 32'h0);
        waitfor(4, 1'b0);
        wr(12'h004, 32'h1);
        waitfor(4, 1'b1);
        wr(12'h000, 32'h2);
        sleepReq <= 1'b1;
        waitfor(2, 1'b1);
        waitfor(4, 1'b0);
        detReady <= 1'b0;
        sleepReq <= 1'b0;
        repeat (10) @(posedge clk);
        check("cpuRun", 32'(cpuRun), 32'h0);
        detReady <= 1'b1;
        waitfor(1, 1'b1);
        wr(12'h000, 32'h3);
        sleepReq <= 1'b1;
        waitfor(2, 1'b1);
        waitfor(4, 1'b1);
        sleepReq <= 1'b0;
        waitfor(1, 1'b1);
        wr(12'h000, 32'h0);
        detReady <= 1'b0;
        sleepReq <= 1'b1;
        waitfor(2, 1'b1);
        sleepReq <= 1'b0;
        waitfor(1, 1'b1);
        close_out();
    end
endmodule : bormc_top_test
`default_nettype wire
